// >>> hdl/io_port_consts.vh
// constants for the microcontroller io port unit
`ifndef IO_PORT_CONSTS_VH
`define IO_PORT_CONSTS_VH
`define OP_NONE      4'h0
`define OP_IN        4'h1
`define OP_OUT       4'h2
`define OP_AND       4'h3
`define OP_OR        4'h4
`define OP_BUS_IN    4'h5
`define OP_BUS_OUT   4'h6
`define OP_BUS_AND   4'h7
`define OP_BUS_OR    4'h8
`define OP_XREAD     4'h9
`define OP_XWRITE    4'ha
`define OP_EXP_IN    4'hb
`define OP_EXP_OUT   4'hc
`define OP_EXP_AND   4'hd
`define OP_EXP_OR    4'he
`define PORT_ONE     3'h1
`define PORT_TWO     3'h2
`define PORT_EXP_LO  3'h4
`define LATCH_RESET  8'hff
`define EXP_CMD_READ  2'h0
`define EXP_CMD_WRITE 2'h1
`define EXP_CMD_OR    2'h2
`define EXP_CMD_AND   2'h3
`define NIB_LO       3
`define NIB_HI       7
`define EXP_READ_WAIT 3'h4
`endif

// >>> hdl/io_port_unit.v
// input/output port unit: two general ports, data port, expander path
// How it works
// - two 8-bit general ports, written from and read into the accumulator
// - general outputs latched; inputs sampled from pins at read time
// - and/or immediate on a general port combines latch with mask
// - general pin works as input after a one sits in its latch
// - data port readable, writable, usable as latched static port
// - data port latch supports and/or immediate with instruction mask
// - data port direction is whole-port, never per bit
// - external data move pulses read or write strobe; data valid then
// - strobed data port floats when no transfer is in progress
// - expander path uses low half of general port 2
// - expander ports 4 to 7; one selected per expander operation
// - expander and/or combine selected port with accumulator
// - external data address comes from pointer register zero or one
// - general port and/or immediate: two bytes, two machine cycles
// - data port and/or immediate: two bytes, two machine cycles
// - expander writes: one byte, two machine cycles; expander reads take six
// - expander and with accumulator: one byte, two machine cycles
// - external data read into accumulator: six machine cycles
// - port designator picks port 1, 2, or expander 4 to 7
// - expander and uses only low four accumulator bits as mask
`include "io_port_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module io_port_unit (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       clk_en,
	input  wire       op_valid,
	input  wire [3:0] op_code,
	input  wire [2:0] port_designator,
	input  wire [7:0] acc_in,
	input  wire [7:0] imm_mask,
	input  wire       ptr_sel,
	input  wire [7:0] pointer_reg_zero,
	input  wire [7:0] pointer_reg_one,
	output wire       op_ready,
	output reg        acc_load,
	output reg  [7:0] acc_out,
	input  wire [7:0] p1_in,
	output reg  [7:0] p1_out,
	output reg  [7:0] p1_oe,
	input  wire [7:0] p2_in,
	output reg  [7:0] p2_out,
	output reg  [7:0] p2_oe,
	output reg        prog_strobe,
	input  wire [7:0] bus_in,
	output reg  [7:0] bus_out,
	output reg        bus_oe,
	output reg        rd_strobe_n,
	output reg        wr_strobe_n,
	output reg        addr_latch
);
	localparam ST_IDLE = 3'b001;
	localparam ST_ONE  = 3'b010;
	localparam ST_TWO  = 3'b100;

	reg [2:0] state_r;
	reg [3:0] op_r;
	reg [2:0] pd_r;
	reg [7:0] acc_r;
	reg [7:0] mask_r;
	reg [7:0] addr_r;
	reg [7:0] p1_lat_r;
	reg [7:0] p2_lat_r;
	reg [7:0] bus_lat_r;
	reg       bus_static_r;
	reg [2:0] wait_r;
	reg [7:0] p1_s1_r, p1_s2_r, p1_s3_r, p1_q_r;
	reg [7:0] p2_s1_r, p2_s2_r, p2_s3_r, p2_q_r;
	reg [7:0] bs_s1_r, bs_s2_r, bs_s3_r, bs_q_r;

	// is this opcode one that drives the expander path
	function is_exp;
		input [3:0] op;
		begin
			is_exp = (op == `OP_EXP_IN) || (op == `OP_EXP_OUT) ||
			         (op == `OP_EXP_AND) || (op == `OP_EXP_OR);
		end
	endfunction

	// selected general port pin value
	function [7:0] gen_pins;
		input [2:0] pd;
		input [7:0] a;
		input [7:0] b;
		begin
			gen_pins = (pd == `PORT_TWO) ? b : a;
		end
	endfunction

	// three-stage pin sampling; change counted when stages 2 and 3 agree
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_sync
			always @(posedge ref_clk) begin
				if (rst) begin
					p1_s1_r[g] <= 1'b1;
					p1_s2_r[g] <= 1'b1;
					p1_s3_r[g] <= 1'b1;
					p1_q_r[g]  <= 1'b1;
					p2_s1_r[g] <= 1'b1;
					p2_s2_r[g] <= 1'b1;
					p2_s3_r[g] <= 1'b1;
					p2_q_r[g]  <= 1'b1;
					bs_s1_r[g] <= 1'b0;
					bs_s2_r[g] <= 1'b0;
					bs_s3_r[g] <= 1'b0;
					bs_q_r[g]  <= 1'b0;
				end else if (clk_en) begin
					p1_s1_r[g] <= p1_in[g];
					p1_s2_r[g] <= p1_s1_r[g];
					p1_s3_r[g] <= p1_s2_r[g];
					if (p1_s2_r[g] == p1_s3_r[g])
						p1_q_r[g] <= p1_s3_r[g];
					p2_s1_r[g] <= p2_in[g];
					p2_s2_r[g] <= p2_s1_r[g];
					p2_s3_r[g] <= p2_s2_r[g];
					if (p2_s2_r[g] == p2_s3_r[g])
						p2_q_r[g] <= p2_s3_r[g];
					bs_s1_r[g] <= bus_in[g];
					bs_s2_r[g] <= bs_s1_r[g];
					bs_s3_r[g] <= bs_s2_r[g];
					if (bs_s2_r[g] == bs_s3_r[g])
						bs_q_r[g] <= bs_s3_r[g];
				end
			end
		end
	endgenerate

	assign op_ready = state_r[0];

	wire [1:0] exp_port = pd_r[1:0];
	wire [1:0] exp_cmd =
		(op_r == `OP_EXP_IN)  ? `EXP_CMD_READ :
		(op_r == `OP_EXP_OUT) ? `EXP_CMD_WRITE :
		(op_r == `OP_EXP_OR)  ? `EXP_CMD_OR : `EXP_CMD_AND;
	// expander and external data reads through the synchronisers must outwait their lag
	wire read_hold = state_r[2] && wait_r != `EXP_READ_WAIT &&
		(op_r == `OP_EXP_IN || op_r == `OP_XREAD);

	always @(posedge ref_clk) begin
		if (rst) begin
			state_r      <= ST_IDLE;
			op_r         <= `OP_NONE;
			pd_r         <= 3'h0;
			acc_r        <= 8'h00;
			mask_r       <= 8'h00;
			addr_r       <= 8'h00;
			p1_lat_r     <= `LATCH_RESET;
			p2_lat_r     <= `LATCH_RESET;
			bus_lat_r    <= 8'h00;
			bus_static_r <= 1'b0;
			wait_r       <= 3'h0;
			acc_load     <= 1'b0;
			acc_out      <= 8'h00;
			prog_strobe  <= 1'b0;
			rd_strobe_n  <= 1'b1;
			wr_strobe_n  <= 1'b1;
			addr_latch   <= 1'b0;
		end else if (clk_en && read_hold) begin
			// strobe and float stay put while the data settles
			wait_r <= wait_r + 3'h1;
		end else if (clk_en) begin
			acc_load <= 1'b0;
			wait_r   <= 3'h0;
			case (state_r)
			ST_IDLE: begin
				if (op_valid && op_code != `OP_NONE) begin
					op_r   <= op_code;
					pd_r   <= port_designator;
					acc_r  <= acc_in;
					mask_r <= imm_mask;
					// pointer register picks the external address
					addr_r <= ptr_sel ? pointer_reg_one
					                  : pointer_reg_zero;
					state_r <= ST_ONE;
					if (is_exp(op_code)) begin
						// send port number and command on nibble
						prog_strobe <= 1'b1;
					end
					if (op_code == `OP_XREAD || op_code == `OP_XWRITE) begin
						addr_latch   <= 1'b1;
						bus_static_r <= 1'b0;
					end
				end
			end
			ST_ONE: begin
				addr_latch <= 1'b0;
				state_r    <= ST_TWO;
				case (op_r)
				`OP_XREAD:  rd_strobe_n <= 1'b0;
				`OP_XWRITE: wr_strobe_n <= 1'b0;
				default: ;
				endcase
				if (is_exp(op_r))
					prog_strobe <= 1'b0;
			end
			ST_TWO: begin
				state_r     <= ST_IDLE;
				rd_strobe_n <= 1'b1;
				wr_strobe_n <= 1'b1;
				case (op_r)
				`OP_IN: begin
					// pins, not latch, at read time
					acc_out  <= (pd_r == `PORT_TWO) ? p2_q_r : p1_q_r;
					acc_load <= 1'b1;
				end
				`OP_OUT: begin
					if (pd_r == `PORT_TWO)
						p2_lat_r <= acc_r;
					else
						p1_lat_r <= acc_r;
				end
				`OP_AND: begin
					if (pd_r == `PORT_TWO)
						p2_lat_r <= p2_lat_r & mask_r;
					else
						p1_lat_r <= p1_lat_r & mask_r;
				end
				`OP_OR: begin
					if (pd_r == `PORT_TWO)
						p2_lat_r <= p2_lat_r | mask_r;
					else
						p1_lat_r <= p1_lat_r | mask_r;
				end
				`OP_BUS_IN: begin
					bus_static_r <= 1'b0;
					acc_out      <= bs_q_r;
					acc_load     <= 1'b1;
				end
				`OP_BUS_OUT: begin
					bus_lat_r    <= acc_r;
					bus_static_r <= 1'b1;
				end
				`OP_BUS_AND: bus_lat_r <= bus_lat_r & mask_r;
				`OP_BUS_OR:  bus_lat_r <= bus_lat_r | mask_r;
				`OP_XREAD: begin
					acc_out  <= bs_q_r;
					acc_load <= 1'b1;
				end
				`OP_EXP_IN: begin
					acc_out  <= {4'h0, p2_q_r[`NIB_LO:0]};
					acc_load <= 1'b1;
				end
				default: ;
				endcase
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// pin drive; a latch one is a weak high so outside can pull it
	always @* begin
		p1_out = p1_lat_r;
		p1_oe  = ~p1_lat_r;
		p2_out = p2_lat_r;
		p2_oe  = ~p2_lat_r;
		if (is_exp(op_r) && !state_r[0]) begin
			// low nibble carries command, then data
			p2_oe[`NIB_LO:0] = 4'hf;
			if (state_r[1])
				p2_out[`NIB_LO:0] = {exp_cmd, exp_port};
			else if (op_r == `OP_EXP_IN)
				p2_oe[`NIB_LO:0] = 4'h0;
			else if (op_r == `OP_EXP_AND)
				p2_out[`NIB_LO:0] = acc_r[`NIB_LO:0];
			else
				p2_out[`NIB_LO:0] = acc_r[`NIB_LO:0];
		end
		bus_out = bus_lat_r;
		bus_oe  = bus_static_r;
		if (!state_r[0] && op_r == `OP_XREAD) begin
			bus_out = addr_r;
			bus_oe  = state_r[1];
		end else if (!state_r[0] && op_r == `OP_XWRITE) begin
			bus_out = state_r[1] ? addr_r : acc_r;
			bus_oe  = 1'b1;
		end else if (!bus_static_r) begin
			bus_oe = 1'b0;
		end
	end
endmodule // io_port_unit
`default_nettype wire

// >>> tb/io_port_chk.sv
// assertion checker on the port unit's pins
`timescale 1ns/1ps
`default_nettype none
`include "io_port_consts.vh"
module io_port_chk (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       op_valid,
	input wire logic [3:0] op_code,
	input wire logic [2:0] port_designator,
	input wire logic       op_ready,
	input wire logic       acc_load,
	input wire logic [7:0] p1_out,
	input wire logic [7:0] p1_oe,
	input wire logic [7:0] p2_out,
	input wire logic       prog_strobe,
	input wire logic       bus_oe,
	input wire logic       rd_strobe_n,
	input wire logic       wr_strobe_n
);
	wire take = op_valid && op_ready && op_code != 4'h0;
	wire rd = op_code == `OP_IN || op_code == `OP_BUS_IN ||
		op_code == `OP_XREAD || op_code == `OP_EXP_IN;
	wire [1:0] cmd = op_code == `OP_EXP_IN ? `EXP_CMD_READ :
		op_code == `OP_EXP_OUT ? `EXP_CMD_WRITE :
		op_code == `OP_EXP_OR ? `EXP_CMD_OR : `EXP_CMD_AND;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	busy_two_a: assert property (take |=> !op_ready [*2])
		else $error("busy");
	wire slow = op_code == `OP_EXP_IN || op_code == `OP_XREAD;
	ready_back_a: assert property (take && !slow |-> ##[3:4] op_ready)
		else $error("ready");
	read_load_a: assert property (take && rd && !slow |-> ##[2:4] acc_load)
		else $error("load");
	slow_read_a: assert property (take && slow |-> ##7 acc_load)
		else $error("slow read");
	pin_release_a: assert property (p1_oe == ~p1_out)
		else $error("oe");
	read_float_a: assert property (!rd_strobe_n |-> !bus_oe)
		else $error("float");
	write_drive_a: assert property (!wr_strobe_n |-> bus_oe)
		else $error("drive");
	exp_select_a: assert property (take && op_code >= `OP_EXP_IN |=>
		prog_strobe && p2_out[3:0] ==
		{$past(cmd), $past(port_designator[1:0])}) else $error("exp");
	reset_ones_a: assert property (disable iff (1'b0) rst |=>
		p1_out == `LATCH_RESET && p2_out == `LATCH_RESET)
		else $error("reset");
endmodule // io_port_chk
`default_nettype wire

// >>> tb/io_port_peer.sv
// pins with pull-ups, expander and external memory beside the unit
`timescale 1ns/1ps
`default_nettype none
module io_port_peer (
	input  wire logic       ref_clk,
	input  wire logic [7:0] p1_oe,
	input  wire logic [7:0] p2_oe,
	input  wire logic [7:0] p1_out,
	input  wire logic [7:0] p2_out,
	input  wire logic       prog_strobe,
	input  wire logic [7:0] bus_out,
	input  wire logic       bus_oe,
	input  wire logic       rd_strobe_n,
	input  wire logic       wr_strobe_n,
	input  wire logic       addr_latch,
	input  wire logic [7:0] pin_drv,
	input  wire logic       exp_en,
	output logic      [7:0] p1_in,
	output logic      [7:0] p2_in,
	output logic      [7:0] bus_in
);
	logic [7:0] mem [0:255];
	logic [3:0] xp [0:3];
	logic [7:0] adr = 8'h00, junk = 8'h5a;
	logic [3:0] cmd = 4'h0;
	logic       ph = 1'b0;
	wire  [3:0] lo = p2_out[3:0];
	wire        quiet = prog_strobe || ph && cmd[3:2] != 2'h0;
	wire  [7:0] far2 = {pin_drv[7:4],
		exp_en ? (quiet ? 4'hf : xp[cmd[1:0]]) : pin_drv[3:0]};
	// a driven pin shows the unit's value, a released one the far side
	assign p1_in = (p1_oe & p1_out) | (~p1_oe & pin_drv);
	assign p2_in = (p2_oe & p2_out) | (~p2_oe & far2);
	// released bus shows memory under a read strobe, otherwise a walking pattern, never the last value
	assign bus_in = bus_oe ? bus_out : !rd_strobe_n ? mem[adr] : junk;
	always @(posedge ref_clk) begin
		junk <= {junk[6:0], ~junk[7]};
		if (addr_latch) adr <= bus_out;
		if (!wr_strobe_n) mem[adr] <= bus_out;
		if (prog_strobe) cmd <= lo;
		ph <= prog_strobe;
		if (ph && cmd[3:2] == 2'h1) xp[cmd[1:0]] <= lo;
		if (ph && cmd[3:2] == 2'h2) xp[cmd[1:0]] <= xp[cmd[1:0]] | lo;
		if (ph && cmd[3:2] == 2'h3) xp[cmd[1:0]] <= xp[cmd[1:0]] & lo;
	end
endmodule // io_port_peer
`default_nettype wire

// >>> tb/microcontroller_io_port_unit_tb.sv
// self-checking bench for the port unit
`timescale 1ns/1ps
`default_nettype none
`include "io_port_consts.vh"
module microcontroller_io_port_unit_tb;
	logic ref_clk = 0, rst = 1, clk_en = 1, op_valid = 0, ptr_sel = 0;
	logic exp_en = 0;
	logic [3:0] op_code = 4'h0, e;
	logic [2:0] port_designator = 3'h1, p;
	logic [7:0] acc_in = 0, imm_mask = 0, pin_drv = 8'hff, a, m, got;
	logic [7:0] pointer_reg_zero = 0, pointer_reg_one = 0, lat [0:3];
	wire op_ready, acc_load, prog_strobe, bus_oe;
	wire rd_strobe_n, wr_strobe_n, addr_latch;
	wire [7:0] acc_out, p1_in, p1_out, p1_oe, p2_in, p2_out, p2_oe;
	wire [7:0] bus_in, bus_out;
	logic [15:0] seed = 16'h06e3;
	int bad_count = 0, num_checks = 0;
	io_port_unit i_dut (.*);
	io_port_peer i_peer (.*);
	always #2 ref_clk = ~ref_clk;
	function automatic logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction
	task automatic final_report();
		if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] x, g);
		num_checks++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic op(input logic [3:0] c, input logic [2:0] d,
		input logic [7:0] v, k);
		op_code <= c;
		port_designator <= d;
		acc_in <= v;
		imm_mask <= k;
		op_valid <= 1;
		@(posedge ref_clk);
		op_code <= `OP_OUT; // must be refused while busy
		acc_in <= ~v;
		@(posedge ref_clk);
		op_valid <= 0;
		for (int n = 0; n < 12; n++) begin
			@(posedge ref_clk);
			if (acc_load === 1'b1) got = acc_out;
			if (n >= 2 && op_ready === 1'b1) return;
		end
		bad_count++;
		final_report();
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 0;
		@(posedge ref_clk);
		chk("p1_out", `LATCH_RESET, p1_out);
		for (int i = 0; i < 8; i++) begin
			p = i[0] ? 3'h2 : 3'h1;
			a = rnd();
			m = rnd();
			pin_drv <= rnd();
			op(`OP_OUT, p, a, 0);
			op(`OP_AND, p, rnd(), m);
			op(`OP_OR, p, rnd(), 8'h11);
			lat[p[1:0]] = (a & m) | 8'h11;
			chk("latch", lat[p[1:0]], p[0] ? p1_out : p2_out);
			repeat (3) @(posedge ref_clk);
			op(`OP_IN, p, rnd(), 0);
			chk("port in", lat[p[1:0]] & pin_drv, got);
		end
		a = rnd();
		m = rnd();
		op(`OP_BUS_OUT, 0, a, 0);
		op(`OP_BUS_AND, 0, rnd(), m);
		op(`OP_BUS_OR, 0, rnd(), 8'h81);
		chk("bus", (a & m) | 8'h81, bus_oe ? bus_out : 8'h00);
		op(`OP_BUS_IN, 0, rnd(), 0);
		chk("bus oe", 0, {7'h0, bus_oe});
		for (int j = 0; j < 3; j++) begin
			a = rnd();
			m = rnd();
			pointer_reg_zero <= m;
			pointer_reg_one <= ~m;
			ptr_sel <= 0;
			op(`OP_XWRITE, 0, a, 0);
			pointer_reg_zero <= ~m;
			pointer_reg_one <= m;
			ptr_sel <= 1;
			op(`OP_XREAD, 0, rnd(), 0);
			chk("xread", a, got);
			chk("bus oe", 0, {7'h0, bus_oe});
		end
		exp_en <= 1;
		for (int k = 0; k < 4; k++) begin
			a = rnd();
			m = rnd();
			p = 3'h4 + k[2:0];
			op(`OP_EXP_OUT, p, a, 0);
			op(`OP_EXP_OR, p, m, 0);
			op(`OP_EXP_AND, p, m ^ 8'h5a, 0);
			e = (a[3:0] | m[3:0]) & (m[3:0] ^ 4'ha);
			repeat (3) @(posedge ref_clk);
			op(`OP_EXP_IN, p, rnd(), 0);
			chk("exp in", {4'h0, e}, got & 8'h0f);
		end
		final_report();
	end
endmodule // microcontroller_io_port_unit_tb
bind io_port_unit io_port_chk i_chk (.*);
`default_nettype wire
